// ===== verilog/smc_params.svh
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
// I/O ports of the indexed configuration space.
`define SMC_PORT_INDEX 16'h0022
`define SMC_PORT_DATA 16'h0023
// Configuration register indices.
`define SMC_IDX_CTRL 8'hc1
`define SMC_IDX_BASE_HI 8'hce
`define SMC_IDX_BASE_LO 8'hcf
// Control register field positions.
`define SMC_CTRL_SMI_EN_BIT 1
`define SMC_CTRL_CODE_ACC_BIT 2
`define SMC_CTRL_MAIN_MEM_BIT 3
`define SMC_CTRL_REGION4_BIT 7
// Reset values and the read value of an unknown index.
`define SMC_RESET_CTRL 8'h00
`define SMC_RESET_BASE_HI 8'h00
`define SMC_RESET_BASE_LO 8'h00
`define SMC_UNMAPPED_READ 8'hff
// Size code 1 is 4 KB, each step doubles, code 13 is 16 MB.
`define SMC_SIZE_MAX_CODE 4'hd
`define SMC_SIZE_SHIFT 11
// Opcode bytes that follow the 0f escape.
`define SMC_OPC_SAVE_SEG 8'h78
`define SMC_OPC_REST_SEG 8'h79
`define SMC_OPC_SAVE_LDT 8'h7a
`define SMC_OPC_REST_LDT 8'h7b
`define SMC_OPC_SAVE_TR 8'h7c
`define SMC_OPC_REST_TR 8'h7d
`define SMC_OPC_RESUME 8'haa
// Cycle costs and pin timing, in core clocks.
`define SMC_CLK_RESTORE 14
`define SMC_CLK_SAVE 22
`define SMC_CLK_RESUME 58
`define SMC_SMI_MIN_LOW 4
`define SMC_RESUME_HIGH 2
`endif

// ===== verilog/smc_pkg.sv
package smc_pkg;
    // Mode of the management controller.
    typedef enum logic [2:0] {
        SMC_ST_NORMAL = 3'b001,
        SMC_ST_HANDLER = 3'b010,
        SMC_ST_RELEASE = 3'b100
    } smc_state_type;
    // Kind of special instruction.
    typedef enum logic [1:0] {
        SMC_OP_NONE = 2'h0,
        SMC_OP_SAVE = 2'h1,
        SMC_OP_RESTORE = 2'h2,
        SMC_OP_RESUME = 2'h3
    } smc_op_type;
    // Register moved by a save or restore.
    typedef enum logic [1:0] {
        SMC_TGT_SEG = 2'h0,
        SMC_TGT_LDT = 2'h1,
        SMC_TGT_TR = 2'h2
    } smc_target_type;
endpackage

// ===== verilog/smc_opcode_decode.sv
`timescale 1ns/10ps
`include "smc_params.svh"
module smc_opcode_decode (
    // Second opcode byte.
    input wire logic [7:0] opcode,
    // Decoded meaning.
    output smc_pkg::smc_op_type opKind,
    output smc_pkg::smc_target_type opTarget,
    output logic [5:0] opClocks
);
    import smc_pkg::*;

    // Map each special opcode to its kind, target and cost.
    always_comb begin
        opKind = SMC_OP_NONE;
        opTarget = SMC_TGT_SEG;
        opClocks = 6'h00;
        case (opcode)
            `SMC_OPC_REST_SEG, `SMC_OPC_REST_LDT, `SMC_OPC_REST_TR: begin
                opKind = SMC_OP_RESTORE;
                opClocks = 6'(`SMC_CLK_RESTORE);
            end
            `SMC_OPC_SAVE_SEG, `SMC_OPC_SAVE_LDT, `SMC_OPC_SAVE_TR: begin
                opKind = SMC_OP_SAVE;
                opClocks = 6'(`SMC_CLK_SAVE);
            end
            `SMC_OPC_RESUME: begin
                opKind = SMC_OP_RESUME;
                opClocks = 6'(`SMC_CLK_RESUME);
            end
            default: begin
                opKind = SMC_OP_NONE;
            end
        endcase
        // Bits 2:1 of the opcode pick segment, LDT or task register.
        case (opcode[2:1])
            2'h1: opTarget = SMC_TGT_LDT;
            2'h2: opTarget = SMC_TGT_TR;
            default: opTarget = SMC_TGT_SEG;
        endcase
    end
endmodule

// ===== verilog/smc_control.sv
`timescale 1ns/10ps
`include "smc_params.svh"
// Function
// - Main-memory bit: in a handler, unprefixed data in the region uses the normal strobe, code stays.
// - Registers reached by index at port 22h, data at port 23h; control at c1h.
// - On entry code base is region base, pointer zero, limit region size minus one.
// - Address bit 20 mask is ignored for accesses on the management strobe.
// - Special instructions run outside the region if code-access bit or handler active.
// - During a handler, region code fetches never go to main memory.
// - Only the nonmaskable interrupt is enabled on handler entry.
// - Management memory accesses are never cacheable.
// - Entry code segment value is truncated to 16 bits.
// - Illegal use of a special instruction raises undefined-opcode.
// - Other segment registers keep hidden limits and attributes on entry.
// - Control bit 1 enables the interrupt pin; bit 7 makes region four management.
// - Region register bits 15-4 give base, bits 3-0 size, 4 KB to 16 MB.
// - Base 23-16 at index ceh; base 15-12 and size code at index cfh.
// - Special instructions need privilege 0 and full enables or an active handler.
// - The interrupt pin is driven low from recognition until resume.
// - Opcodes 0f 79, 7b, 7d restore segment, LDT and task register.
// - Opcodes 0f 78, 7a, 7c save segment, LDT and task register.
// - Restore takes 14 clocks, save 22, resume 58.
// - Opcode 0f aa restores state, leaves management mode and returns.
// - Save and restore move an 80-bit image with hidden descriptor.
// - Save and restore need a mod r/m byte; override prefixes are accepted.
// - Management space accesses use the management strobe, not the normal one.
// - Resume drives the pin high two clocks, then releases it.
// - In normal mode with code-access bit, region accesses use the management strobe.
module smc_control (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Configuration I/O port access.
    input wire logic [15:0] ioAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData_q,
    // Management interrupt pin, open drain.
    input wire logic smiPinIn,
    output logic smiPinOut_q,
    output logic smiPinOeN_q,
    // Memory access request from the core.
    input wire logic accReq,
    input wire logic [23:0] accAddr,
    input wire logic accIsCode,
    input wire logic accCsPrefix,
    input wire logic addr20MaskN,
    output logic mgmtSpaceStrobeN_q,
    output logic normalSpaceStrobeN_q,
    output logic [23:0] busAddr_q,
    output logic accCacheable_q,
    // Special instruction issue.
    input wire logic instrValid,
    input wire logic [7:0] instrOpcode,
    input wire logic instrHasModrm,
    input wire logic [1:0] cpl,
    input wire logic [15:0] segSelIn,
    input wire logic [63:0] segDescIn,
    input wire logic [79:0] memImageIn,
    output logic instrBusy_q,
    output logic instrDone_q,
    output logic undefOpcode_q,
    output logic [79:0] memImageOut_q,
    output logic [79:0] restoreImage_q,
    output smc_pkg::smc_target_type opTarget_q,
    // Execution context on entry and exit.
    output logic enterPulse_q,
    output logic exitToTask_q,
    output logic [23:0] csBase_q,
    output logic [23:0] csLimit_q,
    output logic [15:0] csSelector_q,
    output logic [31:0] eip_q,
    output logic nmiOnly_q,
    output logic keepHidden_q
);
    import smc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic smiSync1_q, smiSync2_q, a20Sync1_q, a20Sync2_q;

    // Both pins are asynchronous; only the second stage is read.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            smiSync1_q <= 1'b1;
            smiSync2_q <= 1'b1;
            a20Sync1_q <= 1'b1;
            a20Sync2_q <= 1'b1;
        end else begin
            smiSync1_q <= smiPinIn;
            smiSync2_q <= smiSync1_q;
            a20Sync1_q <= addr20MaskN;
            a20Sync2_q <= a20Sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    logic [7:0] indexReg_q, indexReg_d, ctrlReg_q, ctrlReg_d;
    logic [7:0] baseHigh_q, baseHigh_d, baseLowSize_q, baseLowSize_d, ioRdData_d;
    logic smiPinEn, mgmtCodeAccessEn, mainMemDataAccessEn, region4MgmtSelect;
    logic [3:0] mgmtSizeField;
    logic [23:0] mgmtBaseField, regionSize, regionMask;
    logic sizeValid;

    assign smiPinEn = ctrlReg_q[`SMC_CTRL_SMI_EN_BIT];
    assign region4MgmtSelect = ctrlReg_q[`SMC_CTRL_REGION4_BIT];
    assign mgmtCodeAccessEn = ctrlReg_q[`SMC_CTRL_CODE_ACC_BIT];
    assign mainMemDataAccessEn = ctrlReg_q[`SMC_CTRL_MAIN_MEM_BIT];
    assign mgmtSizeField = baseLowSize_q[3:0];
    assign mgmtBaseField = {baseHigh_q, baseLowSize_q[7:4], 12'h000};
    // Codes above 16 MB are treated as no region, like code zero.
    assign sizeValid = (mgmtSizeField != 4'h0) && (mgmtSizeField <= `SMC_SIZE_MAX_CODE);
    // The shift sum needs five bits; at 16 MB the one shifts out and the mask is all ones.
    assign regionSize = sizeValid ? (24'h000001 << (5'(mgmtSizeField) + 5'(`SMC_SIZE_SHIFT)))
                                  : 24'h000000;
    assign regionMask = regionSize - 24'h000001;

    // Index port selects, data port reads or writes the selected register.
    always_comb begin
        indexReg_d = indexReg_q;
        ctrlReg_d = ctrlReg_q;
        baseHigh_d = baseHigh_q;
        baseLowSize_d = baseLowSize_q;
        ioRdData_d = ioRdData_q;
        if (ioWrite && ioAddr == `SMC_PORT_INDEX) begin
            indexReg_d = ioWrData;
        end else if (ioWrite && ioAddr == `SMC_PORT_DATA) begin
            case (indexReg_q)
                `SMC_IDX_CTRL: ctrlReg_d = ioWrData;
                `SMC_IDX_BASE_HI: baseHigh_d = ioWrData;
                `SMC_IDX_BASE_LO: baseLowSize_d = ioWrData;
                default: ctrlReg_d = ctrlReg_q;
            endcase
        end
        if (ioRead && ioAddr == `SMC_PORT_INDEX) begin
            ioRdData_d = indexReg_q;
        end else if (ioRead && ioAddr == `SMC_PORT_DATA) begin
            case (indexReg_q)
                `SMC_IDX_CTRL: ioRdData_d = ctrlReg_q;
                `SMC_IDX_BASE_HI: ioRdData_d = baseHigh_q;
                `SMC_IDX_BASE_LO: ioRdData_d = baseLowSize_q;
                default: ioRdData_d = `SMC_UNMAPPED_READ;
            endcase
        end
    end

    // Register the configuration state.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            indexReg_q <= 8'h00;
            ctrlReg_q <= `SMC_RESET_CTRL;
            baseHigh_q <= `SMC_RESET_BASE_HI;
            baseLowSize_q <= `SMC_RESET_BASE_LO;
            ioRdData_q <= 8'h00;
        end else begin
            indexReg_q <= indexReg_d;
            ctrlReg_q <= ctrlReg_d;
            baseHigh_q <= baseHigh_d;
            baseLowSize_q <= baseLowSize_d;
            ioRdData_q <= ioRdData_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode control, strobes and special instructions.
    smc_state_type state_q, state_d;
    smc_op_type decKind, opKind_q, opKind_d;
    smc_target_type decTarget, opTarget_d;
    logic [5:0] decClocks, count_q, count_d;
    logic [2:0] lowCount_q, lowCount_d;
    logic [1:0] highCount_q, highCount_d;
    logic inHandler, inRegion, useMgmt, legal, issueOk, exitNow;
    logic smiPinOut_d, smiPinOeN_d, mgmtN_d, normalN_d, cacheable_d;
    logic busy_d, done_d, undef_d, enter_d, exit_d, nmiOnly_d, keepHidden_d;
    logic [23:0] busAddr_d, csBase_d, csLimit_d;
    logic [15:0] csSelector_d;
    logic [79:0] imageOut_d, restoreImage_d;

    smc_opcode_decode decoder (
        .opcode(instrOpcode),
        .opKind(decKind),
        .opTarget(decTarget),
        .opClocks(decClocks)
    );

    // Handler in progress means the pin is being held low by this block.
    assign inHandler = (state_q == SMC_ST_HANDLER);
    assign inRegion = region4MgmtSelect && sizeValid
                      && (((accAddr ^ mgmtBaseField) & ~regionMask) == 24'h000000);
    // Pick the strobe: region code in a handler always stays in management space.
    assign useMgmt = inRegion && (inHandler
                     ? (accIsCode || accCsPrefix || !mainMemDataAccessEn)
                     : mgmtCodeAccessEn);
    // Allowed outside the region too; no address check is made here.
    assign legal = (cpl == 2'h0) && ((mgmtCodeAccessEn && smiPinEn && region4MgmtSelect
                   && sizeValid) || inHandler);
    assign issueOk = instrValid && !instrBusy_q && legal && decKind != SMC_OP_NONE
                     && (decKind == SMC_OP_RESUME || instrHasModrm);
    assign exitNow = instrBusy_q && count_q == 6'h01 && opKind_q == SMC_OP_RESUME;

    always_comb begin
        state_d = state_q;
        lowCount_d = lowCount_q;
        highCount_d = highCount_q;
        smiPinOut_d = smiPinOut_q;
        smiPinOeN_d = smiPinOeN_q;
        enter_d = 1'b0;
        exit_d = 1'b0;
        csBase_d = csBase_q;
        csLimit_d = csLimit_q;
        csSelector_d = csSelector_q;
        nmiOnly_d = nmiOnly_q;
        keepHidden_d = keepHidden_q;
        // The chipset must hold the pin low four clocks before it is taken.
        lowCount_d = (smiSync2_q || !smiPinEn) ? 3'h0
                     : (lowCount_q == 3'(`SMC_SMI_MIN_LOW)) ? lowCount_q : lowCount_q + 3'h1;
        case (state_q)
            SMC_ST_NORMAL: begin
                if (lowCount_q == 3'(`SMC_SMI_MIN_LOW) && smiPinEn) begin
                    state_d = SMC_ST_HANDLER;
                    smiPinOut_d = 1'b0;
                    smiPinOeN_d = 1'b0;
                    enter_d = 1'b1;
                    csBase_d = mgmtBaseField;
                    csLimit_d = regionMask;
                    csSelector_d = mgmtBaseField[19:4];
                    nmiOnly_d = 1'b1;
                    keepHidden_d = 1'b1;
                end
            end
            SMC_ST_HANDLER: begin
                if (exitNow) begin
                    state_d = SMC_ST_RELEASE;
                    smiPinOut_d = 1'b1;
                    highCount_d = 2'(`SMC_RESUME_HIGH - 1);
                    exit_d = 1'b1;
                    nmiOnly_d = 1'b0;
                    keepHidden_d = 1'b0;
                end
            end
            SMC_ST_RELEASE: begin
                lowCount_d = 3'h0;
                highCount_d = highCount_q - 2'h1;
                if (highCount_q == 2'h0) begin
                    state_d = SMC_ST_NORMAL;
                    smiPinOeN_d = 1'b1;
                end
            end
            default: begin
                state_d = SMC_ST_NORMAL;
                smiPinOut_d = 1'b1;
                smiPinOeN_d = 1'b1;
            end
        endcase
        // A resume run through the code-access path outside a handler still returns.
        if (exitNow && !inHandler) begin
            exit_d = 1'b1;
        end
    end

    // Memory strobes; one access per request, strobe low for one cycle.
    always_comb begin
        mgmtN_d = 1'b1;
        normalN_d = 1'b1;
        busAddr_d = busAddr_q;
        cacheable_d = accCacheable_q;
        if (accReq) begin
            mgmtN_d = !useMgmt;
            normalN_d = useMgmt;
            // The mask pin gates bit 20 only on normal-space cycles.
            busAddr_d = useMgmt ? accAddr
                        : {accAddr[23:21], accAddr[20] & a20Sync2_q, accAddr[19:0]};
            cacheable_d = !useMgmt && !inRegion;
        end
    end

    // Special instruction sequencing; the counter runs the documented cost.
    always_comb begin
        busy_d = instrBusy_q;
        count_d = count_q;
        opKind_d = opKind_q;
        opTarget_d = opTarget_q;
        done_d = 1'b0;
        undef_d = 1'b0;
        imageOut_d = memImageOut_q;
        restoreImage_d = restoreImage_q;
        if (instrBusy_q) begin
            count_d = count_q - 6'h01;
            if (count_q == 6'h01) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end else if (instrValid && !issueOk) begin
            undef_d = 1'b1;
        end else if (issueOk) begin
            busy_d = 1'b1;
            count_d = decClocks;
            opKind_d = decKind;
            opTarget_d = decTarget;
            if (decKind == SMC_OP_SAVE) begin
                imageOut_d = {segDescIn, segSelIn};
            end else if (decKind == SMC_OP_RESTORE) begin
                restoreImage_d = memImageIn;
            end
        end
    end

    // Register all control state; outputs come straight from these flops.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= SMC_ST_NORMAL;
            lowCount_q <= 3'h0;
            highCount_q <= 2'h0;
            smiPinOut_q <= 1'b1;
            smiPinOeN_q <= 1'b1;
            enterPulse_q <= 1'b0;
            exitToTask_q <= 1'b0;
            csBase_q <= 24'h000000;
            csLimit_q <= 24'h000000;
            csSelector_q <= 16'h0000;
            eip_q <= 32'h00000000;
            nmiOnly_q <= 1'b0;
            keepHidden_q <= 1'b0;
            mgmtSpaceStrobeN_q <= 1'b1;
            normalSpaceStrobeN_q <= 1'b1;
            busAddr_q <= 24'h000000;
            accCacheable_q <= 1'b0;
            instrBusy_q <= 1'b0;
            count_q <= 6'h00;
            opKind_q <= SMC_OP_NONE;
            opTarget_q <= SMC_TGT_SEG;
            instrDone_q <= 1'b0;
            undefOpcode_q <= 1'b0;
            memImageOut_q <= 80'h0;
            restoreImage_q <= 80'h0;
        end else begin
            state_q <= state_d;
            lowCount_q <= lowCount_d;
            highCount_q <= highCount_d;
            smiPinOut_q <= smiPinOut_d;
            smiPinOeN_q <= smiPinOeN_d;
            enterPulse_q <= enter_d;
            exitToTask_q <= exit_d;
            csBase_q <= csBase_d;
            csLimit_q <= csLimit_d;
            csSelector_q <= csSelector_d;
            eip_q <= 32'h00000000;
            nmiOnly_q <= nmiOnly_d;
            keepHidden_q <= keepHidden_d;
            mgmtSpaceStrobeN_q <= mgmtN_d;
            normalSpaceStrobeN_q <= normalN_d;
            busAddr_q <= busAddr_d;
            accCacheable_q <= cacheable_d;
            instrBusy_q <= busy_d;
            count_q <= count_d;
            opKind_q <= opKind_d;
            opTarget_q <= opTarget_d;
            instrDone_q <= done_d;
            undefOpcode_q <= undef_d;
            memImageOut_q <= imageOut_d;
            restoreImage_q <= restoreImage_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and covers.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    pin_held_low_a: assert property (inHandler |-> !smiPinOut_q && !smiPinOeN_q)
        else $error("Interrupt pin not driven low in handler.");
    entry_context_a: assert property (enterPulse_q |-> csBase_q == mgmtBaseField
        && csLimit_q == regionMask && eip_q == 32'h0 && nmiOnly_q)
        else $error("Entry context wrong.");
    region_code_a: assert property (accReq && accIsCode && inHandler && inRegion
        |=> !mgmtSpaceStrobeN_q && normalSpaceStrobeN_q)
        else $error("Region code fetch left management space.");
    main_mem_data_a: assert property (accReq && !accIsCode && !accCsPrefix && inRegion
        && inHandler && mainMemDataAccessEn |=> !normalSpaceStrobeN_q)
        else $error("Main memory data access used wrong strobe.");
    mask_ignored_a: assert property (accReq && useMgmt |=> busAddr_q == $past(accAddr))
        else $error("Address bit 20 masked on management access.");
    no_cache_a: assert property (accReq && useMgmt |=> !accCacheable_q)
        else $error("Management access marked cacheable.");
    undef_raise_a: assert property (instrValid && !instrBusy_q && cpl != 2'h0
        |=> undefOpcode_q && !instrBusy_q)
        else $error("Privileged special instruction not refused.");
    restore_cost_a: assert property (issueOk && decKind == SMC_OP_RESTORE
        |=> instrBusy_q ##14 instrDone_q)
        else $error("Restore cost wrong.");
    save_cost_a: assert property (issueOk && decKind == SMC_OP_SAVE
        |=> instrBusy_q ##22 instrDone_q)
        else $error("Save cost wrong.");
    release_high_a: assert property (exitNow && inHandler |=> (smiPinOut_q && !smiPinOeN_q)[*2]
        ##1 smiPinOeN_q)
        else $error("Pin release sequence wrong.");

    entry_seen_c: cover property (enterPulse_q);
    resume_seen_c: cover property (exitToTask_q && state_q == SMC_ST_RELEASE);
    undef_seen_c: cover property (undefOpcode_q);
endmodule

// ===== test/smc_chipset_model.sv
`timescale 1ns/10ps
`include "smc_params.svh"
module smc_chipset_model (
    // Clock and bench request.
    input wire logic core_clk,
    input wire logic pullReq,
    // Device side of the open-drain pin.
    input wire logic smiPinOut_q,
    input wire logic smiPinOeN_q,
    // Resolved pin level.
    output logic smiWire
);
    logic [3:0] lowCnt_q = 4'h0;
    // Pull for the shortest legal request, so a device that needs more is caught.
    always @(posedge core_clk) begin
        if (pullReq) begin
            lowCnt_q <= 4'(`SMC_SMI_MIN_LOW);
        end else if (lowCnt_q != 4'h0) begin
            lowCnt_q <= lowCnt_q - 4'h1;
        end
    end
    // Pull-up on the line: any party driving low wins.
    assign smiWire = (lowCnt_q != 4'h0 || (!smiPinOeN_q && !smiPinOut_q)) ? 1'b0 : 1'b1;
endmodule

// ===== test/system_mgmt_mode_control_tb_top.sv
`timescale 1ns/10ps
`include "smc_params.svh"
module system_mgmt_mode_control_tb_top;
    import smc_pkg::*;
    logic core_clk, reset_n, ioWrite, ioRead, smiPinIn, accReq, accIsCode, accCsPrefix;
    logic addr20MaskN, instrValid, instrHasModrm, pullReq;
    logic [15:0] ioAddr, segSelIn, csSelector_q;
    logic [7:0] ioWrData, ioRdData_q, instrOpcode;
    logic [1:0] cpl;
    logic [23:0] accAddr, busAddr_q, csBase_q, csLimit_q;
    logic [63:0] segDescIn;
    logic [79:0] memImageIn, memImageOut_q, restoreImage_q;
    logic smiPinOut_q, smiPinOeN_q, mgmtSpaceStrobeN_q, normalSpaceStrobeN_q, accCacheable_q;
    logic instrBusy_q, instrDone_q, undefOpcode_q, enterPulse_q, exitToTask_q;
    logic nmiOnly_q, keepHidden_q;
    logic [31:0] eip_q;
    smc_target_type opTarget_q;
    int error_cnt = 0, n_tests = 0, cycles = 0;
    smc_control DUT (.core_clk, .reset_n, .ioAddr, .ioWrite, .ioRead, .ioWrData, .ioRdData_q,
        .smiPinIn, .smiPinOut_q, .smiPinOeN_q, .accReq, .accAddr, .accIsCode, .accCsPrefix,
        .addr20MaskN, .mgmtSpaceStrobeN_q, .normalSpaceStrobeN_q, .busAddr_q, .accCacheable_q,
        .instrValid, .instrOpcode, .instrHasModrm, .cpl, .segSelIn, .segDescIn, .memImageIn,
        .instrBusy_q, .instrDone_q, .undefOpcode_q, .memImageOut_q, .restoreImage_q,
        .opTarget_q, .enterPulse_q, .exitToTask_q, .csBase_q, .csLimit_q, .csSelector_q,
        .eip_q, .nmiOnly_q, .keepHidden_q);
    smc_chipset_model PEER (.core_clk, .pullReq, .smiPinOut_q, .smiPinOeN_q,
        .smiWire(smiPinIn));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock, and a ceiling well above the few hundred cycles the run needs.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            results();
        end
    end
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Port cycles: one request per falling edge, dropped at the next one.
    task automatic io(input logic [7:0] port, input logic wr, input logic [7:0] d);
        @(negedge core_clk);
        ioAddr = {8'h00, port};
        ioWrite = wr;
        ioRead = !wr;
        ioWrData = d;
        @(negedge core_clk);
        ioWrite = 1'b0;
        ioRead = 1'b0;
    endtask
    task automatic cfg(input logic [7:0] idx, input logic [7:0] d, input logic [7:0] exp);
        io(8'h22, 1'b1, idx);
        io(8'h23, 1'b1, d);
        io(8'h22, 1'b1, idx);
        io(8'h23, 1'b0, 8'h00);
        chk(ioRdData_q, exp);
    endtask
    // One memory access; the expected strobe is the management one when mg is set.
    task automatic acc(input logic [23:0] a, input logic code, input logic cs, input logic mg);
        @(negedge core_clk);
        accReq = 1'b1;
        accAddr = a;
        accIsCode = code;
        accCsPrefix = cs;
        @(negedge core_clk);
        accReq = 1'b0;
        chk(mgmtSpaceStrobeN_q, !mg);
        chk(normalSpaceStrobeN_q, mg);
        if (mg) chk(accCacheable_q, 1'b0);
        chk(busAddr_q, mg ? a : {a[23:21], a[20] & addr20MaskN, a[19:0]});
    endtask
    // Offer an instruction; n is the expected busy length, 0 means a refusal.
    task automatic issue(input logic [7:0] op, input logic [1:0] pl, input int n);
        int cnt;
        @(negedge core_clk);
        instrValid = 1'b1;
        instrOpcode = op;
        cpl = pl;
        instrHasModrm = (op != `SMC_OPC_RESUME);
        @(negedge core_clk);
        instrValid = 1'b0;
        cnt = 0;
        while (instrBusy_q === 1'b1 && cnt < 100) begin
            cnt++;
            @(negedge core_clk);
        end
        chk(cnt, n);
        chk(undefOpcode_q, n == 0);
        chk(instrDone_q, n != 0);
        if (n == `SMC_CLK_SAVE) chk(memImageOut_q, {segDescIn, segSelIn});
        if (n == `SMC_CLK_RESTORE) chk(restoreImage_q, memImageIn);
        if (n != 0 && op != `SMC_OPC_RESUME) chk(opTarget_q, (op - 8'h78) >> 1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {ioWrite, ioRead, accReq, accIsCode, accCsPrefix, instrValid, pullReq} = '0;
        {ioAddr, ioWrData, accAddr, instrOpcode, instrHasModrm, cpl} = '0;
        // Bit 20 mask held active so both strobe paths show whether it is applied.
        addr20MaskN = 1'b0;
        segSelIn = 16'h1234;
        segDescIn = 64'h0123456789abcdef;
        memImageIn = 80'h0102030405060708090a;
        reset_n = 1'b0;
        repeat (4) @(negedge core_clk);
        reset_n = 1'b1;
        // Region at 1c8000, above 1 MB, 8 KB, with pin, code access and region select on.
        cfg(8'hc1, 8'h86, 8'h86);
        cfg(8'hce, 8'h1c, 8'h1c);
        cfg(8'hcf, 8'h82, 8'h82);
        cfg(8'hc0, 8'h55, `SMC_UNMAPPED_READ);
        io(8'h22, 1'b0, 8'h00);
        chk(ioRdData_q, 8'hc0);
        issue(`SMC_OPC_REST_SEG, 2'h3, 0);
        issue(`SMC_OPC_REST_LDT, 2'h0, `SMC_CLK_RESTORE);
        issue(`SMC_OPC_SAVE_TR, 2'h0, `SMC_CLK_SAVE);
        acc(24'h1c9000, 1'b0, 1'b0, 1'b1);
        acc(24'h1ca000, 1'b1, 1'b0, 1'b0);
        // Clearing the code-access bit makes the instructions illegal outside a handler.
        cfg(8'hc1, 8'h82, 8'h82);
        issue(`SMC_OPC_SAVE_SEG, 2'h0, 0);
        // Entry: chipset pulls the pin, device must take it over.
        @(negedge core_clk);
        pullReq = 1'b1;
        @(negedge core_clk);
        pullReq = 1'b0;
        repeat (30) if (smiPinOeN_q !== 1'b0) @(negedge core_clk);
        chk({smiPinOeN_q, smiPinOut_q, enterPulse_q}, 3'b001);
        chk({csBase_q, csLimit_q, eip_q}, {24'h1c8000, 24'h001fff, 32'h0});
        chk(csSelector_q, 16'hc800);
        chk({nmiOnly_q, keepHidden_q}, 2'b11);
        issue(`SMC_OPC_SAVE_LDT, 2'h0, `SMC_CLK_SAVE);
        issue(`SMC_OPC_REST_TR, 2'h0, `SMC_CLK_RESTORE);
        cfg(8'hc1, 8'h8a, 8'h8a);
        acc(24'h1c8010, 1'b0, 1'b0, 1'b0);
        acc(24'h1c8010, 1'b0, 1'b1, 1'b1);
        acc(24'h1c8020, 1'b1, 1'b0, 1'b1);
        chk(smiPinOeN_q, 1'b0);
        issue(`SMC_OPC_RESUME, 2'h0, `SMC_CLK_RESUME);
        chk({smiPinOeN_q, smiPinOut_q, exitToTask_q}, 3'b011);
        @(negedge core_clk);
        chk({smiPinOeN_q, smiPinOut_q}, 2'b01);
        @(negedge core_clk);
        chk(smiPinOeN_q, 1'b1);
        chk(nmiOnly_q, 1'b0);
        results();
    end
endmodule
